//--- src/ilwc_pkg.sv
// constants, register map and types of the implant link wake-up controller
package ilwc_pkg;
   localparam int CLK_HZ          = 100_000_000;
   localparam int CLK_MHZ         = CLK_HZ / 1_000_000;
   // direct wake pulse must exceed 1.5 ms
   localparam int DIRECT_WAKE_NS  = 1_500_000;
   localparam int DIRECT_WAKE_CYC = (DIRECT_WAKE_NS * CLK_MHZ + 999) / 1000;
   // wake receiver sniff period 200 us
   localparam int SNIFF_NS        = 200_000;
   localparam int SNIFF_CYC       = (SNIFF_NS * CLK_MHZ) / 1000;
   // internal strobe oscillator 25 kHz
   localparam int STROSC_HZ       = 25_000;
   localparam int STROSC_CYC      = CLK_HZ / STROSC_HZ;
   // on-off keyed bit period for the external wake transmitter
   localparam int OOK_BIT_CYC     = 100;

   localparam logic [7:0] ADR_CTRL      = 8'h00;
   localparam logic [7:0] ADR_COMM      = 8'h04;
   localparam logic [7:0] ADR_STATUS    = 8'h08;
   localparam logic [7:0] ADR_SNIFF_IVL = 8'h0C;
   localparam logic [7:0] ADR_OOK_PAT   = 8'h10;
   localparam logic [7:0] ADR_RESP_GAP  = 8'h14;
   localparam logic [7:0] ADR_IRQ_STAT  = 8'h18;
   localparam logic [7:0] ADR_IRQ_MASK  = 8'h1C;

   localparam int CTRL_FLAG_BIT   = 0;
   localparam int CTRL_STROSC_BIT = 1;
   localparam int CTRL_PINSTR_BIT = 2;
   localparam int COMM_WAKE_BIT   = 0;
   localparam int COMM_SESS_BIT   = 1;
   localparam int COMM_STOP_BIT   = 2;
   localparam int STAT_MODE_BIT   = 4;

   localparam int IRQ_W           = 4;
   localparam int IRQ_DIRECT_BIT  = 0;
   localparam int IRQ_WAKEMSG_BIT = 1;
   localparam int IRQ_BASEMSG_BIT = 2;
   localparam int IRQ_SNIFFTO_BIT = 3;

   localparam logic [2:0]  CTRL_RST      = 3'h5;
   localparam logic [15:0] SNIFF_IVL_RST = 16'h61A8;
   localparam logic [31:0] OOK_PAT_RST   = 32'hA5A5_F00F;
   localparam logic [31:0] RESP_GAP_RST  = 32'h03FF_0400;

   typedef enum logic [2:0] {
      ST_SLEEP,
      ST_SNIFF,
      ST_IDLE,
      ST_BASE_WAKE,
      ST_RESPOND,
      ST_SESSION
   } ilwc_state_t;

   // byte-lane merge for wishbone writes
   function automatic logic [31:0] ilwc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : ilwc_merge
endpackage : ilwc_pkg

//--- src/ilwc_wake_if.sv
// pulse classes passed from the wake pin classifier to the controller
`timescale 1ns/1ns
interface ilwc_wake_if;
   logic long_p;
   logic short_p;
   modport src (output long_p, output short_p);
   modport dst (input long_p, input short_p);
endinterface : ilwc_wake_if

//--- src/ilwc_pulse_class.sv
// wake pin synchroniser and pulse length classifier
`timescale 1ns/1ns
module ilwc_pulse_class #(
   parameter int THRESH_CYC = 150000
) (
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   input  wire logic  wake_pin_i,
   ilwc_wake_if.src   wk
);
   localparam int CW = $clog2(THRESH_CYC + 2);
   localparam logic [CW-1:0] SAT = CW'(THRESH_CYC + 1);

   logic          meta_reg;
   logic          sync_reg;
   logic          prev_reg;
   logic [CW-1:0] cnt_reg;
   logic          long_reg;
   logic          short_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= wake_pin_i;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= '0;
      end else if (sync_reg) begin
         if (cnt_reg != SAT) begin
            cnt_reg <= cnt_reg + CW'(1);
         end
      end else begin
         cnt_reg <= '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         long_reg  <= 1'b0;
         short_reg <= 1'b0;
      end else begin
         long_reg  <= prev_reg && !sync_reg && (cnt_reg > CW'(THRESH_CYC));
         short_reg <= prev_reg && !sync_reg && (cnt_reg <= CW'(THRESH_CYC)) && (cnt_reg != '0);
      end
   end

   assign wk.long_p  = long_reg;
   assign wk.short_p = short_reg;
endmodule : ilwc_pulse_class

//--- src/ilwc_rand_timer.sv
// randomised interval timer for wake-up response packets
`timescale 1ns/1ns
module ilwc_rand_timer #(
   parameter int W = 16
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         run_i,
   input  wire logic [W-1:0] base_i,
   input  wire logic [W-1:0] span_i,
   output logic              tick_o
);
   logic [15:0]  lfsr_reg;
   logic [W-1:0] cnt_reg;
   logic         tick_reg;

   // lfsr free-runs so each start sees a different seed point
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lfsr_reg <= 16'hACE1;
      end else begin
         lfsr_reg <= {1'b0, lfsr_reg[15:1]} ^ (lfsr_reg[0] ? 16'hB400 : 16'h0000);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg  <= '0;
         tick_reg <= 1'b0;
      end else if (!run_i) begin
         cnt_reg  <= base_i;
         tick_reg <= 1'b0;
      end else if (cnt_reg == '0) begin
         cnt_reg  <= base_i + (W'(lfsr_reg) & span_i);
         tick_reg <= 1'b1;
      end else begin
         cnt_reg  <= cnt_reg - W'(1);
         tick_reg <= 1'b0;
      end
   end

   assign tick_o = tick_reg;
endmodule : ilwc_rand_timer

//--- src/ilwc_top.sv
// wake-up and operating mode controller with wishbone registers
// Overview of operation
// - The mode is caught from the select pin just after reset: implant sleeps, base sits idle.
// - With the select pin at 1 the controller starts in IDLE and waits for host commands.
// - A wake pin pulse high for more than 1.5 ms, then low, is a direct wake.
// - A direct wake from sleep or sniff puts the implant in IDLE and sets the wake behaviour flag to 1.
// - Flag 1 keeps the transceiver idle after wake, flag 0 makes it send wake-up responses.
// - A wake-up write to the comm control register in base mode starts the keyed pattern and main-band tx/rx.
// - In implant mode the wake receiver is strobed by the internal oscillator, the wake pin, or both.
// - A responding implant sends wake-up responses and listens for base wake-up messages.
// - Gaps between response packets are randomised.
// - Select pin low means implant operation, high means base-station operation.
// - An internal strobe generator at 25 kHz ticks may replace external wake pin strobes.
// - A short wake pin pulse triggers one sniff period of the wake receiver.
//
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
module ilwc_top
   import ilwc_pkg::*;
#(
   parameter int DIRECT_WAKE_CYCLES = DIRECT_WAKE_CYC,
   parameter int SNIFF_CYCLES       = SNIFF_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   input  wire logic        implant_base_select_i,
   input  wire logic        wake_pin_i,
   input  wire logic        wake_msg_rx_i,
   input  wire logic        base_msg_rx_i,
   output logic             wake_rx_pwr_o,
   output logic             ook_en_o,
   output logic             ook_data_o,
   output logic             mb_tx_en_o,
   output logic             mb_rx_en_o,
   output logic             resp_tx_o,
   output logic             mode_base_o,
   output logic             irq_o
);
   localparam int SCW = $clog2(SNIFF_CYCLES + 1);
   localparam int OCW = $clog2(STROSC_CYC + 1);
   localparam int BCW = $clog2(OOK_BIT_CYC + 1);

   ilwc_state_t         state_reg;
   ilwc_state_t         state_next;
   logic                mode_cap_reg;
   logic                mode_base_reg;
   logic [2:0]          ctrl_reg;
   logic [15:0]         sniff_ivl_reg;
   logic [31:0]         ook_pat_reg;
   logic [31:0]         resp_gap_reg;
   logic [IRQ_W-1:0]    irq_stat_reg;
   logic [IRQ_W-1:0]    irq_mask_reg;
   logic                ack_reg;
   logic [31:0]         dat_reg;
   logic [SCW-1:0]      sniff_cnt_reg;
   logic [OCW-1:0]      osc_cnt_reg;
   logic [15:0]         ivl_cnt_reg;
   logic [BCW-1:0]      bit_cnt_reg;
   logic [4:0]          bit_idx_reg;
   logic                osc_tick;
   logic                osc_strobe;
   logic                pin_strobe;
   logic                sniff_done;
   logic                wr_hit;
   logic                comm_wr;
   logic [31:0]         wdat;
   logic [IRQ_W-1:0]    irq_evt;
   logic                resp_tick;

   ilwc_wake_if wk ();

   ilwc_pulse_class #(
      .THRESH_CYC (DIRECT_WAKE_CYCLES)
   ) u_class (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .wake_pin_i (wake_pin_i),
      .wk         (wk.src)
   );

   ilwc_rand_timer #(
      .W (16)
   ) u_rand (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .run_i  (state_reg == ST_RESPOND),
      .base_i (resp_gap_reg[15:0]),
      .span_i (resp_gap_reg[31:16]),
      .tick_o (resp_tick)
   );

   // ---- wishbone slave: ack one cycle after the request, writes land with ack
   assign wr_hit  = cyc_i && stb_i && we_i && ack_reg;
   assign comm_wr = wr_hit && (adr_i == ADR_COMM);
   assign wdat    = dat_i & {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= cyc_i && stb_i && !ack_reg;
      end
   end

   // unmapped addresses read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_reg <= 32'h0000_0000;
      end else if (cyc_i && stb_i && !ack_reg) begin
         case (adr_i)
            ADR_CTRL:      dat_reg <= {29'h0, ctrl_reg};
            ADR_COMM:      dat_reg <= {29'h0, 3'(state_reg)};
            ADR_STATUS:    dat_reg <= {27'h0, mode_base_reg, 1'b0, 3'(state_reg)};
            ADR_SNIFF_IVL: dat_reg <= {16'h0, sniff_ivl_reg};
            ADR_OOK_PAT:   dat_reg <= ook_pat_reg;
            ADR_RESP_GAP:  dat_reg <= resp_gap_reg;
            ADR_IRQ_STAT:  dat_reg <= {28'h0, irq_stat_reg};
            ADR_IRQ_MASK:  dat_reg <= {28'h0, irq_mask_reg};
            default:       dat_reg <= 32'h0000_0000;
         endcase
      end
   end

   // ---- mode strap, caught on the first edge after reset release
   // capture once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_cap_reg  <= 1'b0;
         mode_base_reg <= 1'b0;
      end else if (!mode_cap_reg) begin
         mode_cap_reg  <= 1'b1;
         mode_base_reg <= implant_base_select_i;
      end
   end

   // ---- control register; hardware set of the flag wins over a host write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= CTRL_RST;
      end else begin
         if (wr_hit && adr_i == ADR_CTRL) begin
            ctrl_reg <= 3'(ilwc_merge({29'h0, ctrl_reg}, dat_i, sel_i));
         end
         if (wk.long_p && !mode_base_reg && mode_cap_reg) begin
            ctrl_reg[CTRL_FLAG_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sniff_ivl_reg <= SNIFF_IVL_RST;
         ook_pat_reg   <= OOK_PAT_RST;
         resp_gap_reg  <= RESP_GAP_RST;
         irq_mask_reg  <= '0;
      end else if (wr_hit) begin
         case (adr_i)
            ADR_SNIFF_IVL: sniff_ivl_reg <= 16'(ilwc_merge({16'h0, sniff_ivl_reg}, dat_i, sel_i));
            ADR_OOK_PAT:   ook_pat_reg   <= ilwc_merge(ook_pat_reg, dat_i, sel_i);
            ADR_RESP_GAP:  resp_gap_reg  <= ilwc_merge(resp_gap_reg, dat_i, sel_i);
            ADR_IRQ_MASK:  irq_mask_reg  <= IRQ_W'(ilwc_merge({28'h0, irq_mask_reg}, dat_i, sel_i));
            default:       irq_mask_reg  <= irq_mask_reg;
         endcase
      end
   end

   // ---- interrupt status: write one to clear, a new event in the same cycle stays set
   assign irq_evt[IRQ_DIRECT_BIT]  = wk.long_p && !mode_base_reg;
   assign irq_evt[IRQ_WAKEMSG_BIT] = (state_reg == ST_SNIFF) && wake_msg_rx_i;
   assign irq_evt[IRQ_BASEMSG_BIT] = (state_reg == ST_RESPOND) && base_msg_rx_i;
   assign irq_evt[IRQ_SNIFFTO_BIT] = sniff_done && !wake_msg_rx_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_reg <= '0;
      end else if (wr_hit && adr_i == ADR_IRQ_STAT) begin
         irq_stat_reg <= (irq_stat_reg & ~wdat[IRQ_W-1:0]) | irq_evt;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_evt;
      end
   end

   // ---- strobe sources for the wake receiver
   // 25 kHz strobe ticks
   always_ff @(posedge clk_i) begin
      if (rst_i || !ctrl_reg[CTRL_STROSC_BIT]) begin
         osc_cnt_reg <= '0;
      end else if (osc_cnt_reg == OCW'(STROSC_CYC - 1)) begin
         osc_cnt_reg <= '0;
      end else begin
         osc_cnt_reg <= osc_cnt_reg + OCW'(1);
      end
   end
   assign osc_tick = ctrl_reg[CTRL_STROSC_BIT] && (osc_cnt_reg == OCW'(STROSC_CYC - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i || !ctrl_reg[CTRL_STROSC_BIT]) begin
         ivl_cnt_reg <= '0;
      end else if (osc_tick) begin
         ivl_cnt_reg <= (ivl_cnt_reg >= sniff_ivl_reg) ? 16'h0000 : ivl_cnt_reg + 16'h0001;
      end
   end
   assign osc_strobe = osc_tick && (ivl_cnt_reg >= sniff_ivl_reg);
   assign pin_strobe = wk.short_p && ctrl_reg[CTRL_PINSTR_BIT];

   always_ff @(posedge clk_i) begin
      if (rst_i || state_reg != ST_SNIFF) begin
         sniff_cnt_reg <= '0;
      end else if (!sniff_done) begin
         sniff_cnt_reg <= sniff_cnt_reg + SCW'(1);
      end
   end
   assign sniff_done = (state_reg == ST_SNIFF) && (sniff_cnt_reg == SCW'(SNIFF_CYCLES - 1));

   // ---- operating state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_SLEEP: begin
            if (wk.long_p) begin
               state_next = ST_IDLE;
            end else if (osc_strobe || pin_strobe) begin
               state_next = ST_SNIFF;
            end
         end
         ST_SNIFF: begin
            if (wk.long_p) begin
               state_next = ST_IDLE;
            end else if (wake_msg_rx_i) begin
               state_next = ST_RESPOND;
            end else if (sniff_done) begin
               state_next = ST_SLEEP;
            end
         end
         ST_IDLE: begin
            if (!mode_base_reg && !ctrl_reg[CTRL_FLAG_BIT]) begin
               state_next = ST_RESPOND;
            end else if (mode_base_reg && comm_wr && dat_i[COMM_WAKE_BIT] && sel_i[0]) begin
               state_next = ST_BASE_WAKE;
            end else if (mode_base_reg && comm_wr && dat_i[COMM_SESS_BIT] && sel_i[0]) begin
               state_next = ST_SESSION;
            end
         end
         ST_BASE_WAKE: begin
            if (comm_wr && dat_i[COMM_STOP_BIT] && sel_i[0]) begin
               state_next = ST_IDLE;
            end else if (comm_wr && dat_i[COMM_SESS_BIT] && sel_i[0]) begin
               state_next = ST_SESSION;
            end
         end
         ST_RESPOND: begin
            if (base_msg_rx_i) begin
               state_next = ST_SESSION;
            end else if (ctrl_reg[CTRL_FLAG_BIT]) begin
               state_next = ST_IDLE;
            end
         end
         ST_SESSION: begin
            if (comm_wr && dat_i[COMM_STOP_BIT] && sel_i[0]) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_SLEEP;
      end else if (!mode_cap_reg) begin
         state_reg <= implant_base_select_i ? ST_IDLE : ST_SLEEP;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---- keyed pattern for the external wake transmitter, lsb first, repeating
   always_ff @(posedge clk_i) begin
      if (rst_i || state_reg != ST_BASE_WAKE) begin
         bit_cnt_reg <= '0;
         bit_idx_reg <= '0;
      end else if (bit_cnt_reg == BCW'(OOK_BIT_CYC - 1)) begin
         bit_cnt_reg <= '0;
         bit_idx_reg <= bit_idx_reg + 5'h01;
      end else begin
         bit_cnt_reg <= bit_cnt_reg + BCW'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ook_en_o      <= 1'b0;
         ook_data_o    <= 1'b0;
         mb_tx_en_o    <= 1'b0;
         mb_rx_en_o    <= 1'b0;
         wake_rx_pwr_o <= 1'b0;
         resp_tx_o     <= 1'b0;
      end else begin
         ook_en_o      <= state_next == ST_BASE_WAKE;
         ook_data_o    <= (state_reg == ST_BASE_WAKE) && ook_pat_reg[bit_idx_reg];
         mb_tx_en_o    <= state_next inside {ST_BASE_WAKE, ST_SESSION};
         mb_rx_en_o    <= state_next inside {ST_BASE_WAKE, ST_RESPOND, ST_SESSION};
         wake_rx_pwr_o <= state_next == ST_SNIFF;
         resp_tx_o     <= (state_reg == ST_RESPOND) && (state_next != ST_IDLE) && resp_tick;
      end
   end

   assign dat_o       = dat_reg;
   assign ack_o       = ack_reg;
   assign mode_base_o = mode_base_reg;
   assign irq_o       = |(irq_stat_reg & irq_mask_reg);
endmodule : ilwc_top

//--- test/ilwc_checker.sv
// port-level assertions for the wake-up controller
`timescale 1ns/1ns
module ilwc_checker
   import ilwc_pkg::*;
#(
   parameter int DIRECT_WAKE_CYCLES = 20,
   parameter int SNIFF_CYCLES       = 16
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic        ack_o,
   input wire logic        implant_base_select_i,
   input wire logic        wake_msg_rx_i,
   input wire logic        wake_rx_pwr_o,
   input wire logic        ook_en_o,
   input wire logic        mb_tx_en_o,
   input wire logic        mb_rx_en_o,
   input wire logic        resp_tx_o,
   input wire logic        mode_base_o
);
   int sniff_cnt;

   // length of the current sniff window so far
   always_ff @(posedge clk_i) begin
      if (rst_i || !wake_rx_pwr_o)
         sniff_cnt <= 0;
      else
         sniff_cnt <= sniff_cnt + 1;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_ack_lat; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack late");
   property p_ack_once; ack_o |=> !ack_o; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held");
   property p_mode_hold; !rst_i [*4] |-> $stable(mode_base_o); endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
   property p_mode_val; !rst_i [*4] |-> mode_base_o == $past(implant_base_select_i, 3); endproperty
   a_mode_val: assert property (p_mode_val) else $error("mode differs from strap");
   property p_base_no_sniff; mode_base_o |-> !wake_rx_pwr_o; endproperty
   a_base_no_sniff: assert property (p_base_no_sniff) else $error("sniff in base");
   property p_implant_no_ook; !mode_base_o |-> !ook_en_o; endproperty
   a_implant_no_ook: assert property (p_implant_no_ook) else $error("keying in implant");
   property p_ook_mb; $rose(ook_en_o) |-> mb_tx_en_o && mb_rx_en_o; endproperty
   a_ook_mb: assert property (p_ook_mb) else $error("keying without main band");
   property p_base_wake;
      ack_o && we_i && adr_i == ADR_COMM && sel_i[0] && dat_i[2:0] == 3'h1 && mode_base_o && !mb_tx_en_o
         && !mb_rx_en_o |-> ##[1:2] (ook_en_o && mb_tx_en_o && mb_rx_en_o);
   endproperty
   a_base_wake: assert property (p_base_wake) else $error("wake write ignored");
   property p_sniff_max; wake_rx_pwr_o |-> sniff_cnt < SNIFF_CYCLES; endproperty
   a_sniff_max: assert property (p_sniff_max) else $error("sniff too long");
   property p_sniff_len; $fell(wake_rx_pwr_o) && !$past(wake_msg_rx_i) |-> sniff_cnt == SNIFF_CYCLES; endproperty
   a_sniff_len: assert property (p_sniff_len) else $error("sniff too short");
   property p_resp_once; resp_tx_o |=> !resp_tx_o; endproperty
   a_resp_once: assert property (p_resp_once) else $error("response pulse held");
   property p_resp_listen; resp_tx_o |-> mb_rx_en_o; endproperty
   a_resp_listen: assert property (p_resp_listen) else $error("response while deaf");
endmodule : ilwc_checker

bind ilwc_top ilwc_checker #(.DIRECT_WAKE_CYCLES(DIRECT_WAKE_CYCLES), .SNIFF_CYCLES(SNIFF_CYCLES)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
   .dat_i(dat_i), .ack_o(ack_o), .implant_base_select_i(implant_base_select_i), .wake_msg_rx_i(wake_msg_rx_i),
   .wake_rx_pwr_o(wake_rx_pwr_o), .ook_en_o(ook_en_o), .mb_tx_en_o(mb_tx_en_o), .mb_rx_en_o(mb_rx_en_o),
   .resp_tx_o(resp_tx_o), .mode_base_o(mode_base_o));

//--- test/ilwc_host_model.sv
// host processor model driving the wake pin
`timescale 1ns/1ns
module ilwc_host_model (
   input  wire logic clk_i,
   output logic      wake_pin_o
);
   initial wake_pin_o = 1'b0;

   // high for n cycles, then low
   task automatic pulse(input int n);
      wake_pin_o <= 1'b1;
      repeat (n) @(posedge clk_i);
      wake_pin_o <= 1'b0;
      // low gap so back-to-back pulses stay apart
      repeat (2) @(posedge clk_i);
   endtask : pulse
endmodule : ilwc_host_model

//--- test/tb.sv
// self-checking bench for the wake-up controller
`timescale 1ns/1ns
module tb
   import ilwc_pkg::*;
();
   localparam int DWC = 20;
   localparam int SNC = 16;
   typedef struct {
      logic        w;
      logic [7:0]  a;
      logic [31:0] d;
      logic [3:0]  s;
      logic [31:0] e;
   } ilwc_row_t;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, strap, wake_pin, wmsg, bmsg;
   logic [7:0]  adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o, rd;
   logic        pwr, ook_en, ook_dat, mb_tx, mb_rx, resp, mode, irq;
   int          error_cnt, n_tests, n;
   ilwc_row_t   rows [13] = '{
      '{1'b0, ADR_CTRL, 32'h0, 4'hF, {29'h0, CTRL_RST}},
      '{1'b0, ADR_STATUS, 32'h0, 4'hF, 32'h0},
      '{1'b0, ADR_SNIFF_IVL, 32'h0, 4'hF, {16'h0, SNIFF_IVL_RST}},
      '{1'b0, ADR_OOK_PAT, 32'h0, 4'hF, OOK_PAT_RST},
      '{1'b0, ADR_RESP_GAP, 32'h0, 4'hF, RESP_GAP_RST},
      '{1'b0, ADR_IRQ_STAT, 32'h0, 4'hF, 32'h0},
      '{1'b0, ADR_IRQ_MASK, 32'h0, 4'hF, 32'h0},
      '{1'b1, ADR_RESP_GAP, 32'h000F_0010, 4'h3, 32'h0},
      '{1'b0, ADR_RESP_GAP, 32'h0, 4'hF, 32'h03FF_0010},
      '{1'b1, ADR_RESP_GAP, 32'h000F_0000, 4'hC, 32'h0},
      '{1'b0, ADR_RESP_GAP, 32'h0, 4'hF, 32'h000F_0010},
      '{1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF, 32'h0},
      '{1'b0, 8'h20, 32'h0, 4'hF, 32'h0}};

   ilwc_top #(.DIRECT_WAKE_CYCLES(DWC), .SNIFF_CYCLES(SNC)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .implant_base_select_i(strap), .wake_pin_i(wake_pin),
      .wake_msg_rx_i(wmsg), .base_msg_rx_i(bmsg), .wake_rx_pwr_o(pwr), .ook_en_o(ook_en), .ook_data_o(ook_dat),
      .mb_tx_en_o(mb_tx), .mb_rx_en_o(mb_rx), .resp_tx_o(resp), .mode_base_o(mode), .irq_o(irq));
   ilwc_host_model u_host (.clk_i(clk_i), .wake_pin_o(wake_pin));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic finish_test();
      if (error_cnt == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one classic cycle; hold until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int t;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= s;
      t = 0;
      do begin
         @(posedge clk_i);
         t++;
      end while (ack_o !== 1'b1 && t < 20);
      if (t >= 20) begin
         error_cnt++;
         finish_test();
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0, 4'hF);
      chk(rd, e);
   endtask : rdc

   // strap only moves while reset is held
   task automatic rst_go(input logic s);
      rst_i <= 1'b1;
      strap <= s;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask : rst_go

   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      finish_test();
   end

   initial begin
      {rst_i, cyc_i, stb_i, we_i, strap, wmsg, bmsg} = 7'h40;
      adr_i = 8'h0;
      sel_i = 4'h0;
      dat_i = 32'h0;
      rst_go(1'b0);
      foreach (rows[i]) begin
         wb(rows[i].w, rows[i].a, rows[i].d, rows[i].s);
         if (!rows[i].w)
            chk(rd, rows[i].e);
      end
      // pulse at the threshold is still a strobe
      u_host.pulse(DWC);
      n = 0;
      while (pwr !== 1'b1 && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      n = 0;
      while (pwr === 1'b1 && n < 99) begin
         @(posedge clk_i);
         n++;
      end
      chk(n, SNC);
      rdc(ADR_STATUS, 32'h0);
      // internal strobe at interval zero sniffs once per oscillator tick
      wb(1'b1, ADR_SNIFF_IVL, 32'h0, 4'hF);
      wb(1'b1, ADR_CTRL, 32'h3, 4'hF);
      n = 0;
      while (pwr !== 1'b1 && n < 4100) begin
         @(posedge clk_i);
         n++;
      end
      chk(n, STROSC_CYC);
      // flag 0 so a wake message keeps the implant responding
      wb(1'b1, ADR_CTRL, 32'h4, 4'hF);
      repeat (SNC) @(posedge clk_i);
      rdc(ADR_IRQ_STAT, 32'h8);
      wb(1'b1, ADR_IRQ_STAT, 32'h8, 4'hF);
      rdc(ADR_IRQ_STAT, 32'h0);
      wmsg <= 1'b1;
      u_host.pulse(5);
      repeat (30) @(posedge clk_i);
      wmsg <= 1'b0;
      rdc(ADR_STATUS, 32'h4);
      chk(mb_rx, 1'b1);
      rdc(ADR_IRQ_STAT, 32'h2);
      n = 0;
      while (resp !== 1'b1 && n < 99) begin
         @(posedge clk_i);
         n++;
      end
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (resp !== 1'b1 && n < 99);
      chk(n >= 17 && n <= 32, 1'b1);
      bmsg <= 1'b1;
      repeat (8) @(posedge clk_i);
      bmsg <= 1'b0;
      rdc(ADR_STATUS, 32'h5);
      chk(irq, 1'b0);
      wb(1'b1, ADR_IRQ_MASK, 32'h4, 4'hF);
      chk(irq, 1'b1);
      wb(1'b1, ADR_IRQ_STAT, 32'h4, 4'hF);
      chk(irq, 1'b0);
      rdc(ADR_IRQ_STAT, 32'h2);
      // direct wake just past the threshold, flag lowered first
      rst_go(1'b0);
      wb(1'b1, ADR_CTRL, 32'h4, 4'hF);
      u_host.pulse(DWC + 1);
      repeat (10) @(posedge clk_i);
      rdc(ADR_STATUS, 32'h2);
      rdc(ADR_CTRL, 32'h5);
      rdc(ADR_IRQ_STAT, 32'h1);
      wb(1'b1, ADR_CTRL, 32'h4, 4'hF);
      rdc(ADR_STATUS, 32'h4);
      wb(1'b1, ADR_CTRL, 32'h5, 4'hF);
      rdc(ADR_STATUS, 32'h2);
      rst_go(1'b1);
      rdc(ADR_STATUS, 32'h12);
      u_host.pulse(DWC + 1);
      repeat (6) @(posedge clk_i);
      rdc(ADR_STATUS, 32'h12);
      wb(1'b1, ADR_COMM, 32'h1, 4'hF);
      @(posedge clk_i);
      chk({ook_en, mb_tx, mb_rx}, 3'h7);
      // sample mid-bit so a one-cycle skew is harmless
      repeat (48) @(posedge clk_i);
      for (int k = 0; k < 16; k++) begin
         chk(ook_dat, OOK_PAT_RST[k]);
         repeat (100) @(posedge clk_i);
      end
      wb(1'b1, ADR_COMM, 32'h2, 4'hF);
      rdc(ADR_STATUS, 32'h15);
      wb(1'b1, ADR_COMM, 32'h4, 4'hF);
      rdc(ADR_STATUS, 32'h12);
      chk(ook_en, 1'b0);
      finish_test();
   end
endmodule : tb
